// ==== mrac_region_check.sv ====
// Memory region access checker and SDRAM row mapper
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mrac_consts.svh"

module mrac_region_check
    import mrac_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Request
    input wire logic req_valid,
    input wire mrac_req_t req_type,
    input wire logic req_remote_node,
    input wire logic req_ua,
    input wire logic [1:0] req_upage,
    input wire logic [1:0] req_row,
    input wire logic [5:0] req_lpage,
    input wire logic req_upper_bus,
    // Answer
    output logic resp_valid,
    output logic resp_err,
    output logic resp_go,
    output mrac_mem_t resp_mem,
    output logic [9:0] resp_key,
    output logic resp_upper_bus,
    output logic [1:0] resp_phys_row,
    output logic [7:0] resp_row_mb
);

    function automatic logic region_hit(input logic [9:0] key, input logic [31:0] r);
        logic [9:0] m;
        logic [9:0] v;
        m = r[`MRAC_REG_MASK_LSB +: `MRAC_KEY_W];
        v = r[`MRAC_REG_VAL_LSB +: `MRAC_KEY_W];
        region_hit = r[`MRAC_REG_EN_BIT] && ((key & m) == (v & m));
    endfunction

    function automatic logic [9:0] force_key(input logic [9:0] key, input logic [31:0] r);
        logic [9:0] m;
        logic [9:0] v;
        m = r[`MRAC_REG_MASK_LSB +: `MRAC_KEY_W];
        v = r[`MRAC_REG_VAL_LSB +: `MRAC_KEY_W];
        force_key = (key & ~m) | (v & m);
    endfunction

    function automatic logic allowed(input mrac_acc_t ac, input mrac_mem_t mt);
        allowed = 1'b0;
        case (ac)
            AC_PROT: allowed = (mt == MT_PMAIN);
            AC_UNPROT: allowed = (mt == MT_UMAIN);
            AC_DIAG: allowed = (mt != MT_NONE);
            AC_FLUSH: allowed = (mt == MT_PCACHE) || (mt == MT_UCACHE);
            AC_RPROT_HAD: allowed = (mt == MT_PMAIN) || (mt == MT_PCACHE);
            AC_RPROT_HAE: allowed = 1'b0;
            AC_RUNPROT: allowed = (mt == MT_UMAIN) || (mt == MT_UCACHE);
            default: allowed = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] row_mb(input logic [1:0] sz);
        case (sz)
            2'h0: row_mb = `MRAC_SIZE_16MB;
            2'h1: row_mb = `MRAC_SIZE_64MB;
            default: row_mb = `MRAC_SIZE_128MB;
        endcase
    endfunction

    // Registers
    logic ha_en_r;
    logic [31:0] umem_r;
    logic [31:0] pcache_r;
    logic [31:0] ucache_r;
    logic [4:0] row_cfg_r [0:7];
    logic [15:0] viol_cnt_r;
    mrac_mem_t last_viol_r;

    // Control and region registers; enables clear at reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ha_en_r <= 1'b0;
            umem_r <= `MRAC_REGION_RST; // see [RQ22]
            pcache_r <= `MRAC_REGION_RST;
            ucache_r <= `MRAC_REGION_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `MRAC_OFS_CTRL: ha_en_r <= reg_wdata[`MRAC_CTRL_HA_BIT];
                `MRAC_OFS_UMEM: umem_r <= reg_wdata;
                `MRAC_OFS_PCACHE: pcache_r <= reg_wdata;
                `MRAC_OFS_UCACHE: ucache_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Row map: one byte per group, low word groups 0-3, high word groups 4-7
    // Deliberately no reset; software must program it before memory is used
    always_ff @(posedge sys_clk) begin
        for (int g = 0; g < 4; g++) begin
            if (reg_wr && reg_addr == `MRAC_OFS_ROW_LO) begin
                row_cfg_r[g] <= reg_wdata[8*g +: `MRAC_ROW_FIELD_W]; // see [RQ21]
            end
            if (reg_wr && reg_addr == `MRAC_OFS_ROW_HI) begin
                row_cfg_r[g+4] <= reg_wdata[8*g +: `MRAC_ROW_FIELD_W]; // see [RQ16]
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped offsets read zero
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (reg_addr)
            `MRAC_OFS_CTRL: rdata_nxt[`MRAC_CTRL_HA_BIT] = ha_en_r;
            `MRAC_OFS_UMEM: rdata_nxt = umem_r;
            `MRAC_OFS_PCACHE: rdata_nxt = pcache_r;
            `MRAC_OFS_UCACHE: rdata_nxt = ucache_r;
            `MRAC_OFS_ROW_LO: begin
                for (int g = 0; g < 4; g++) begin
                    rdata_nxt[8*g +: `MRAC_ROW_FIELD_W] = row_cfg_r[g]; // see [RQ21]
                end
            end
            `MRAC_OFS_ROW_HI: begin
                for (int g = 0; g < 4; g++) begin
                    rdata_nxt[8*g +: `MRAC_ROW_FIELD_W] = row_cfg_r[g+4];
                end
            end
            `MRAC_OFS_STATUS: rdata_nxt = {13'h0000, last_viol_r, viol_cnt_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    logic [31:0] reg_rdata_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            reg_rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
        end
    end
    assign reg_rdata = reg_rdata_r;

    // Request decode
    logic [9:0] key_raw;
    logic [2:0] grp;
    logic [4:0] grp_cfg;
    logic ua_eff;
    logic to_cache;
    logic [9:0] key_nxt;
    mrac_mem_t mem_nxt;
    mrac_acc_t acc_nxt;
    logic err_nxt;

    assign key_raw = {req_upage, req_row, req_lpage};
    assign grp = {req_upper_bus, req_row}; // see [RQ17]
    assign grp_cfg = row_cfg_r[grp];
    assign ua_eff = ha_en_r & req_ua; // see [RQ8]
    // Only processor requests for a remote node get redirected into the cache
    assign to_cache = req_remote_node && (req_type != RT_LINK);

    always_comb begin
        key_nxt = key_raw;
        if (to_cache) begin
            key_nxt = ua_eff ? force_key(key_raw, ucache_r) // see [RQ3]
                             : force_key(key_raw, pcache_r); // see [RQ2] [RQ23]
        end
    end

    always_comb begin
        mem_nxt = MT_PMAIN; // see [RQ6]
        if (to_cache) begin
            mem_nxt = ua_eff ? MT_UCACHE : MT_PCACHE;
        end else if (!grp_cfg[`MRAC_ROW_EXIST_BIT]) begin
            mem_nxt = MT_NONE; // see [RQ7] [RQ19]
        end else if (region_hit(key_raw, pcache_r)) begin
            mem_nxt = MT_PCACHE; // see [RQ4]
        end else if (region_hit(key_raw, ucache_r)) begin
            mem_nxt = MT_UCACHE; // see [RQ5]
        end else if (region_hit(key_raw, umem_r)) begin
            mem_nxt = MT_UMAIN;
        end
    end

    always_comb begin
        acc_nxt = AC_PROT;
        case (req_type) // see [RQ15]
            RT_LOCAL: acc_nxt = ua_eff ? AC_UNPROT : AC_PROT;
            RT_DIAG: acc_nxt = AC_DIAG;
            RT_FLUSH: acc_nxt = AC_FLUSH;
            RT_LINK: begin
                if (ua_eff) begin
                    acc_nxt = AC_RUNPROT;
                end else begin
                    acc_nxt = ha_en_r ? AC_RPROT_HAE : AC_RPROT_HAD;
                end
            end
            default: acc_nxt = AC_PROT;
        endcase
    end

    // Table check; the link-outside-unprotected-region test agrees with it
    assign err_nxt = !allowed(acc_nxt, mem_nxt); // see [RQ9] [RQ10] [RQ11] [RQ12] [RQ13] [RQ14] [RQ1]

    // Answer stage
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            resp_valid <= 1'b0;
            resp_err <= 1'b0;
            resp_go <= 1'b0;
        end else begin
            resp_valid <= req_valid;
            resp_err <= req_valid && err_nxt; // see [RQ24]
            resp_go <= req_valid && !err_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            resp_mem <= MT_PMAIN;
            resp_key <= 10'h000;
            resp_upper_bus <= 1'b0;
            resp_phys_row <= 2'h0;
            resp_row_mb <= 8'h00;
        end else if (req_valid) begin
            resp_mem <= mem_nxt;
            resp_key <= key_nxt;
            // Bus half is carried through unchanged so a row never crosses halves
            resp_upper_bus <= req_upper_bus; // see [RQ20]
            resp_phys_row <= grp_cfg[`MRAC_ROW_INST_LSB +: 2];
            resp_row_mb <= row_mb(grp_cfg[`MRAC_ROW_SIZE_LSB +: 2]); // see [RQ18]
        end
    end

    // Violation statistics; counter saturates instead of wrapping
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            viol_cnt_r <= 16'h0000;
            last_viol_r <= MT_PMAIN;
        end else if (req_valid && err_nxt) begin
            if (viol_cnt_r != 16'hffff) begin
                viol_cnt_r <= viol_cnt_r + 16'h0001;
            end
            last_viol_r <= mem_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    go_err_excl_a: assert property (resp_valid |-> (resp_go ^ resp_err)) // see [RQ24]
        else $error("go and err not exclusive");
    diag_err_a: assert property (req_valid && req_type == RT_DIAG |=>
        resp_err == (resp_mem == MT_NONE)) // see [RQ10]
        else $error("diagnostic error mismatch");
    flush_ok_a: assert property (req_valid && req_type == RT_FLUSH |=>
        resp_go == (resp_mem == MT_PCACHE || resp_mem == MT_UCACHE)) // see [RQ11]
        else $error("flush entry check wrong");
    link_hae_a: assert property (req_valid && req_type == RT_LINK && ha_en_r && !req_ua
        |=> resp_err) // see [RQ13]
        else $error("protected link access passed with availability on");
    local_prot_a: assert property (req_valid && req_type == RT_LOCAL && !ha_en_r
        && !req_remote_node |=> resp_go == (resp_mem == MT_PMAIN)) // see [RQ9]
        else $error("local protected check wrong");
    nonexist_a: assert property (req_valid && !to_cache && !grp_cfg[`MRAC_ROW_EXIST_BIT]
        |=> resp_mem == MT_NONE) // see [RQ7]
        else $error("missing row not nonexistent");
    force_pc_a: assert property (req_valid && to_cache && !ua_eff |=>
        ((resp_key ^ $past(pcache_r[19:10])) & $past(pcache_r[9:0])) == 10'h000) // see [RQ2]
        else $error("protected cache force wrong");
    force_uc_a: assert property (req_valid && to_cache && ua_eff |=>
        resp_mem == MT_UCACHE) // see [RQ3]
        else $error("unprotected cache not selected");
    link_unprot_a: assert property (req_valid && req_type == RT_LINK && ua_eff |=>
        resp_go == (resp_mem == MT_UMAIN || resp_mem == MT_UCACHE)) // see [RQ14] [RQ1]
        else $error("link unprotected check wrong");
    rd_lat_a: assert property (reg_rd && reg_addr == `MRAC_OFS_CTRL |=>
        reg_rdata == {31'h0, $past(ha_en_r)})
        else $error("control readback wrong");

    link_ok_c: cover property (req_valid && req_type == RT_LINK ##1 resp_go);
    flush_ok_c: cover property (req_valid && req_type == RT_FLUSH ##1 resp_go);
    local_err_c: cover property (req_valid && req_type == RT_LOCAL ##1 resp_err);
    cache_fwd_c: cover property (req_valid && to_cache && ua_eff);

endmodule

// ==== mrac_consts.svh ====
// Register map, field positions and decode constants of the region access checker
// Notes on behaviour
// [RQ1] Link requests outside the unprotected region are violations when high availability is on
// [RQ2] Remote address with access bit zero is forced into the protected cache region
// [RQ3] Remote address with access bit one is forced into the unprotected cache region
// [RQ4] Local addresses hitting the protected cache region are rejected as plain memory
// [RQ5] Local addresses hitting the unprotected cache region are rejected as plain memory
// [RQ6] Existing memory outside all three regions is protected main memory
// [RQ7] Coherent addresses whose row is not installed are nonexistent memory
// [RQ8] High availability off means protected; on, the address bit picks the kind
// [RQ9] Local accesses reach only main memory of their own protection kind
// [RQ10] Diagnostic accesses fail only on nonexistent memory
// [RQ11] Flush-entry operations are allowed only on the two cache regions
// [RQ12] Link protected access, availability off: protected main and protected cache allowed
// [RQ13] Link protected access with high availability on always fails
// [RQ14] Link unprotected access allows unprotected main memory and unprotected cache
// [RQ15] Processor requests are local types; link requests come from the link controller
// [RQ16] Two bus halves of four rows; lower and upper groups configured separately
// [RQ17] Row number plus lower/upper bus selects one of eight row setting groups
// [RQ18] Row size field: 0 is 16 Mbyte, 1 is 64 Mbyte, 2 and 3 are 128
// [RQ19] Each group has a row-exists flag telling whether memory is present
// [RQ20] Installed-row field maps the row, staying inside its own bus half
// [RQ21] Row map register is read/write, untouched by reset, reserved bits read zero
// [RQ22] Each region register has an enable bit cleared by reset
// [RQ23] Ten-bit mask picks forced address bits, value gives them, upper page on top
// [RQ24] A violation answers with an error and the memory access is not done
`ifndef MRAC_CONSTS_SVH
`define MRAC_CONSTS_SVH

`define MRAC_OFS_CTRL 8'h00
`define MRAC_OFS_UMEM 8'h04
`define MRAC_OFS_PCACHE 8'h08
`define MRAC_OFS_UCACHE 8'h0c
`define MRAC_OFS_ROW_LO 8'h10
`define MRAC_OFS_ROW_HI 8'h14
`define MRAC_OFS_STATUS 8'h18

`define MRAC_CTRL_HA_BIT 0
`define MRAC_REG_MASK_LSB 0
`define MRAC_REG_VAL_LSB 10
`define MRAC_REG_EN_BIT 31
`define MRAC_REGION_RST 32'h0000_0000
`define MRAC_KEY_W 10

`define MRAC_ROW_SIZE_LSB 0
`define MRAC_ROW_EXIST_BIT 2
`define MRAC_ROW_INST_LSB 3
`define MRAC_ROW_FIELD_W 5

`define MRAC_SIZE_16MB 8'h10
`define MRAC_SIZE_64MB 8'h40
`define MRAC_SIZE_128MB 8'h80

`endif

// ==== mrac_pkg.sv ====
// Types shared by the region access checker
package mrac_pkg;
    typedef enum logic [1:0] {RT_LOCAL, RT_DIAG, RT_FLUSH, RT_LINK} mrac_req_t;
    typedef enum logic [2:0] {MT_PMAIN, MT_UMAIN, MT_PCACHE, MT_UCACHE, MT_NONE} mrac_mem_t;
    typedef enum logic [2:0] {
        AC_PROT, AC_UNPROT, AC_DIAG, AC_FLUSH, AC_RPROT_HAD, AC_RPROT_HAE, AC_RUNPROT
    } mrac_acc_t;
endpackage

// ==== mrac_req_agent.sv ====
// Request source standing in for the local processor agents and the link controller
`timescale 1ns/1ps

module mrac_req_agent
    import mrac_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Request to the checker
    output logic req_valid,
    output mrac_req_t req_type,
    output logic req_remote_node,
    output logic req_ua,
    output logic [1:0] req_upage,
    output logic [1:0] req_row,
    output logic [5:0] req_lpage,
    output logic req_upper_bus
);
    initial begin
        req_valid = 1'b0;
        req_type = RT_LOCAL;
        req_remote_node = 1'b0;
        req_ua = 1'b0;
        {req_upage, req_row, req_lpage} = 10'h0;
        req_upper_bus = 1'b0;
    end

    // Processors issue the first three kinds, only the link side issues RT_LINK
    task automatic send(input mrac_req_t t, input logic rn, input logic ua,
                        input logic [9:0] key, input logic ub, input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_type <= t;
        req_remote_node <= rn;
        req_ua <= ua;
        {req_upage, req_row, req_lpage} <= key;
        req_upper_bus <= ub;
        @(posedge sys_clk);
        // Idle fields flip so that a stale sample cannot pass for the last request
        req_valid <= 1'b0;
        req_type <= mrac_req_t'(~t);
        req_remote_node <= ~rn;
        req_ua <= ~ua;
        {req_upage, req_row, req_lpage} <= ~key;
        req_upper_bus <= ~ub;
        #1;
    endtask
endmodule

// ==== memory_region_access_check_tb_top.sv ====
// Self-checking bench for the region access checker
`timescale 1ns/1ps
`include "mrac_consts.svh"

module memory_region_access_check_tb_top
    import mrac_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic req_valid, req_remote_node, req_ua, req_upper_bus;
    mrac_req_t req_type;
    logic [1:0] req_upage, req_row, resp_phys_row;
    logic [5:0] req_lpage;
    logic resp_valid, resp_err, resp_go, resp_upper_bus;
    mrac_mem_t resp_mem;
    logic [9:0] resp_key;
    logic [7:0] resp_row_mb, b;
    logic [31:0] d;
    int err_count = 0;
    int cmp_count = 0;
    int nexp = 0;
    // Access classes: local prot (HA off, ua set), local unprot, diag, flush, link x3
    mrac_req_t rt [7] = '{RT_LOCAL, RT_LOCAL, RT_DIAG, RT_FLUSH, RT_LINK, RT_LINK, RT_LINK};
    logic [6:0] ua_of = 7'b1000011;
    logic [6:0] ha_of = 7'b1101110;
    logic [4:0] ok_of [7] = '{5'h01, 5'h02, 5'h0f, 5'h0c, 5'h05, 5'h00, 5'h0a};
    logic [31:0] rows [2] = '{32'h1b16_0d04, 32'h0e05_141f};

    always #5 sys_clk = ~sys_clk;

    mrac_req_agent src (.sys_clk(sys_clk), .req_valid(req_valid), .req_type(req_type),
        .req_remote_node(req_remote_node), .req_ua(req_ua), .req_upage(req_upage),
        .req_row(req_row), .req_lpage(req_lpage), .req_upper_bus(req_upper_bus));

    mrac_region_check DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_valid(req_valid), .req_type(req_type), .req_remote_node(req_remote_node),
        .req_ua(req_ua), .req_upage(req_upage), .req_row(req_row), .req_lpage(req_lpage),
        .req_upper_bus(req_upper_bus), .resp_valid(resp_valid), .resp_err(resp_err),
        .resp_go(resp_go), .resp_mem(resp_mem), .resp_key(resp_key),
        .resp_upper_bus(resp_upper_bus), .resp_phys_row(resp_phys_row),
        .resp_row_mb(resp_row_mb));

    task automatic results();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask

    // Read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(n, v, e);
    endtask

    task automatic req(input mrac_req_t t, input logic rn, input logic ua,
                       input logic [9:0] key, input logic ub, input logic e);
        src.send(t, rn, ua, key, ub, 0);
        nexp += e;
        chk("resp_valid", resp_valid, 1'b1);
        chk("resp_err", resp_err, e);
        chk("resp_go", resp_go, !e);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rdchk("ctrl_rst", `MRAC_OFS_CTRL, 32'h0);
        rdchk("umem_rst", `MRAC_OFS_UMEM, 32'h0);
        rdchk("pcache_rst", `MRAC_OFS_PCACHE, 32'h0);
        rdchk("ucache_rst", `MRAC_OFS_UCACHE, 32'h0);
        wr(`MRAC_OFS_ROW_LO, 32'hffff_ffff);
        rdchk("row_rsvd", `MRAC_OFS_ROW_LO, 32'h1f1f_1f1f);
        wr(8'h20, 32'h1234_5678);
        rdchk("unmapped", 8'h20, 32'h0);
        wr(`MRAC_OFS_ROW_LO, rows[0]);
        wr(`MRAC_OFS_ROW_HI, rows[1]);
        rdchk("row_hi", `MRAC_OFS_ROW_HI, rows[1]);
        wr(`MRAC_OFS_UMEM, 32'h8004_0300);
        wr(`MRAC_OFS_PCACHE, 32'h8008_0701);
        wr(`MRAC_OFS_UCACHE, 32'h800c_0300);
        rdchk("pcache_rb", `MRAC_OFS_PCACHE, 32'h8008_0701);
        wr(`MRAC_OFS_CTRL, 32'h1);
        // Group 3 is the only one without memory behind it
        for (int g = 0; g < 8; g++) begin
            b = rows[g / 4][8 * (g % 4) +: 8];
            req(RT_DIAG, 1'b0, 1'b0, {2'b00, g[1:0], 6'h01}, g[2], g == 3);
            chk("row_mb", resp_row_mb,
                b[1:0] == 2'd0 ? 8'h10 : b[1:0] == 2'd1 ? 8'h40 : 8'h80);
            chk("phys_row", resp_phys_row, b[4:3]);
            chk("upper_bus", resp_upper_bus, g[2]);
        end
        // Upper page 0..3 picks main, unprot main, prot cache, unprot cache; row 3 is absent
        for (int a = 0; a < 7; a++) begin
            wr(`MRAC_OFS_CTRL, {31'h0, ha_of[a]});
            for (int m = 0; m < 5; m++) begin
                req(rt[a], 1'b0, ua_of[a], m == 4 ? 10'h0c1 : {m[1:0], 8'h01}, 1'b0,
                    !ok_of[a][m]);
                chk("mem_type", resp_mem, m);
            end
        end
        req(RT_LOCAL, 1'b1, 1'b0, 10'h06a, 1'b0, 1'b1);
        chk("key_pcache", resp_key, 10'h26b);
        chk("mem_pcache", resp_mem, MT_PCACHE);
        req(RT_LOCAL, 1'b1, 1'b1, 10'h06a, 1'b0, 1'b1);
        chk("key_ucache", resp_key, 10'h36a);
        chk("mem_ucache", resp_mem, MT_UCACHE);
        rd(`MRAC_OFS_STATUS, d);
        chk("viol_count", d[15:0], nexp[15:0]);
        // A second reset must clear the regions but keep the row map
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rdchk("row_keep", `MRAC_OFS_ROW_LO, rows[0]);
        rdchk("umem_clr", `MRAC_OFS_UMEM, 32'h0);
        results();
    end

    // The run needs well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
